// File: design/drcs_core.sv
// Run-command and frequency-setpoint selection for a motor drive.
// Assumes keypad and terminal pins are asynchronous, the analogue sample
// arrives on the core clock, and a classic Wishbone master drives the bus.
//
// Overview of operation
// RULE1: command source 0 keypad, 1 terminals
// RULE2: frequency source 0 keypad, 3 analogue
// RULE3: forward input active when its function is 2
// RULE4: reverse input active when its function is 3
// RULE5: only forward closed runs forward, open stops
// RULE6: only reverse closed runs reverse, open stops
// RULE7: both or neither terminal asserted stops motor
// RULE8: keypad run key starts, stop key halts
// RULE9: up/down keys or writes change setpoint
// RULE10: analogue source used when its function is 2
// RULE11: digital setpoint register feeds keypad source
// RULE12: ramp uses acceleration and deceleration times
// RULE13: inputs from unselected sources are ignored
`timescale 1ns/1ps

module drcs_core
  import drcs_pkg::*;
#(
  parameter int ANA_W = 16,
  parameter int TICK_CYC = RAMP_TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_key_run,
  input wire logic i_key_stop,
  input wire logic i_key_up,
  input wire logic i_key_down,
  input wire logic i_forward_run_input,
  input wire logic i_reverse_run_input,
  input wire logic [ANA_W-1:0] i_analog_input_one,
  output logic [15:0] o_out_freq,
  output logic o_reverse,
  output logic o_running
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------------
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] sync1_q, sync2_q, prev_q;
  logic [PIN_N-1:0] edge_s;
  assign pins = {i_reverse_run_input, i_forward_run_input, i_key_down,
                 i_key_up, i_key_stop, i_key_run};
  assign edge_s = sync2_q & ~prev_q;

  // Two flops then a history flop for key edges
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave and register file
  // ----------------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] src_q, src_d, func_q, func_d;
  logic [15:0] setpt_q, setpt_d, accel_q, accel_d, decel_q, decel_d;
  logic bus_wr;
  logic [1:0] cmd_src, freq_src;
  logic [3:0] fwd_fn, rev_fn, ana_fn;
  logic [15:0] freq_q, freq_d;
  logic run_q, run_d, dir_q, dir_d, odir_q, odir_d, runo_q, runo_d;

  assign cmd_src = src_q[SRC_CMD_LSB +: 2];
  assign freq_src = src_q[SRC_FREQ_LSB +: 2];
  assign fwd_fn = func_q[FUNC_FWD_LSB +: 4];
  assign rev_fn = func_q[FUNC_REV_LSB +: 4];
  assign ana_fn = func_q[FUNC_ANA_LSB +: 4];
  // Write commits at the edge where the master sees ack
  assign bus_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_q;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0] sel,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  // Ack, read mux and register writes
  always_comb begin
    ack_d = i_wb_cyc && i_wb_stb && !ack_q;
    rdat_d = '0;
    src_d = src_q;
    func_d = func_q;
    accel_d = accel_q;
    decel_d = decel_q;
    if (i_wb_adr == REG_SRC_SEL) begin
      rdat_d = src_q;
    end else if (i_wb_adr == REG_IN_FUNC) begin
      rdat_d = func_q;
    end else if (i_wb_adr == REG_SETPOINT) begin
      rdat_d = {16'h0000, setpt_q};
    end else if (i_wb_adr == REG_ACCEL) begin
      rdat_d = {16'h0000, accel_q};
    end else if (i_wb_adr == REG_DECEL) begin
      rdat_d = {16'h0000, decel_q};
    end else if (i_wb_adr == REG_STATUS) begin
      rdat_d = {16'h0000, freq_q};
      rdat_d[STAT_RUN_BIT] = runo_q;
      rdat_d[STAT_REV_BIT] = odir_q;
      rdat_d[STAT_CMD_BIT] = run_q;
    end
    if (bus_wr) begin
      if (i_wb_adr == REG_SRC_SEL) begin
        src_d = merge(src_q, i_wb_dat, i_wb_sel, MASK_SRC_SEL);
      end else if (i_wb_adr == REG_IN_FUNC) begin
        func_d = merge(func_q, i_wb_dat, i_wb_sel, MASK_IN_FUNC);
      end else if (i_wb_adr == REG_ACCEL) begin
        accel_d = 16'(merge({16'h0000, accel_q}, i_wb_dat, i_wb_sel, MASK_HALF)); // [RULE12]
      end else if (i_wb_adr == REG_DECEL) begin
        decel_d = 16'(merge({16'h0000, decel_q}, i_wb_dat, i_wb_sel, MASK_HALF)); // [RULE12]
      end
    end
  end

  // Bus registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      src_q <= RST_SRC_SEL;
      func_q <= RST_IN_FUNC;
      accel_q <= RST_ACCEL;
      decel_q <= RST_DECEL;
    end else begin
      ack_q <= ack_d;
      rdat_q <= ack_d ? rdat_d : '0;
      src_q <= src_d;
      func_q <= func_d;
      accel_q <= accel_d;
      decel_q <= decel_d;
    end
  end

  // ----------------------------------------------------------------------
  // Digital setpoint: bus write wins over keys
  // ----------------------------------------------------------------------
  logic sp_wr, key_up, key_dn;
  assign sp_wr = bus_wr && (i_wb_adr == REG_SETPOINT);
  assign key_up = (freq_src == FREQ_SRC_KEYPAD) && edge_s[PIN_UP]; // [RULE13]
  assign key_dn = (freq_src == FREQ_SRC_KEYPAD) && edge_s[PIN_DOWN]; // [RULE13]

  always_comb begin
    setpt_d = setpt_q;
    if (sp_wr) begin
      setpt_d = 16'(merge({16'h0000, setpt_q}, i_wb_dat, i_wb_sel, MASK_HALF)); // [RULE9]
    end else if (key_up && !key_dn) begin
      setpt_d = (setpt_q > FREQ_MAX - FREQ_KEY_STEP) ? FREQ_MAX : setpt_q + FREQ_KEY_STEP; // [RULE9]
    end else if (key_dn && !key_up) begin
      setpt_d = (setpt_q < FREQ_KEY_STEP) ? 16'h0000 : setpt_q - FREQ_KEY_STEP; // [RULE9]
    end
  end

  // Setpoint register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      setpt_q <= RST_SETPOINT; // [RULE11]
    end else begin
      setpt_q <= setpt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Run command selection
  // ----------------------------------------------------------------------
  logic fwd_en, rev_en;
  assign fwd_en = sync2_q[PIN_FWD] && (fwd_fn == FUNC_FORWARD_RUN); // [RULE3]
  assign rev_en = sync2_q[PIN_REV] && (rev_fn == FUNC_REVERSE_RUN); // [RULE4]

  always_comb begin
    run_d = 1'b0;
    dir_d = dir_q;
    case (cmd_src) // [RULE1] [RULE13]
      CMD_SRC_KEYPAD: begin
        dir_d = 1'b0;
        if (edge_s[PIN_STOP]) begin
          run_d = 1'b0; // [RULE8]
        end else if (edge_s[PIN_RUN]) begin
          run_d = 1'b1; // [RULE8]
        end else begin
          run_d = run_q;
        end
      end
      CMD_SRC_TERMINAL: begin
        run_d = fwd_en ^ rev_en; // [RULE5] [RULE6] [RULE7]
        if (fwd_en ^ rev_en) begin
          dir_d = rev_en;
        end
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Frequency target and ramp
  // ----------------------------------------------------------------------
  logic [15:0] ana_freq, src_freq, tgt;
  logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_q, tick_cnt_d;
  logic [15:0] ramp_cnt_q, ramp_cnt_d;
  logic tick, ramp_step;

  assign ana_freq = (16'(i_analog_input_one) > FREQ_MAX) ? FREQ_MAX : 16'(i_analog_input_one);
  assign tick = (tick_cnt_q == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));

  // Source mux then direction-aware target
  always_comb begin
    src_freq = 16'h0000;
    if (freq_src == FREQ_SRC_KEYPAD) begin
      src_freq = setpt_q; // [RULE2] [RULE11]
    end else if (freq_src == FREQ_SRC_ANALOG && ana_fn == FUNC_ANALOG_FREQ) begin
      src_freq = ana_freq; // [RULE2] [RULE10]
    end
    tgt = (run_q && dir_q == odir_q) ? src_freq : 16'h0000;
  end

  // Ramp steps one unit each accel/decel time plus one, in ticks
  always_comb begin
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    ramp_cnt_d = ramp_cnt_q;
    ramp_step = 1'b0;
    freq_d = freq_q;
    if (freq_q == tgt) begin
      ramp_cnt_d = '0;
    end else if (tick) begin
      if (ramp_cnt_q >= ((freq_q < tgt) ? accel_q : decel_q)) begin // [RULE12]
        ramp_cnt_d = '0;
        ramp_step = 1'b1;
        freq_d = (freq_q < tgt) ? freq_q + 16'h0001 : freq_q - 16'h0001;
      end else begin
        ramp_cnt_d = ramp_cnt_q + 16'h0001;
      end
    end
    odir_d = (freq_q == 16'h0000) ? dir_q : odir_q;
    runo_d = run_d || (freq_d != 16'h0000);
  end

  // Run, direction and ramp registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
      dir_q <= 1'b0;
      odir_q <= 1'b0;
      runo_q <= 1'b0;
      freq_q <= '0;
      tick_cnt_q <= '0;
      ramp_cnt_q <= '0;
    end else begin
      run_q <= run_d;
      dir_q <= dir_d;
      odir_q <= odir_d;
      runo_q <= runo_d;
      freq_q <= freq_d;
      tick_cnt_q <= tick_cnt_d;
      ramp_cnt_q <= ramp_cnt_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_out_freq = freq_q;
  assign o_reverse = odir_q;
  assign o_running = runo_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  chk_bus_ack_once: assert property (s_req |=> s_ack_pulse)
    else $error("bus ack not a single pulse after request");
  chk_keypad_stop: assert property ( // [RULE8]
    (cmd_src == CMD_SRC_KEYPAD && edge_s[PIN_STOP]) |=> !run_q)
    else $error("keypad stop did not halt");
  chk_keypad_start: assert property ( // [RULE8]
    (cmd_src == CMD_SRC_KEYPAD && edge_s[PIN_RUN] && !edge_s[PIN_STOP]) |=> run_q && !dir_q)
    else $error("keypad run did not start forward");
  chk_term_forward: assert property ( // [RULE5]
    (cmd_src == CMD_SRC_TERMINAL && fwd_en && !rev_en) |=> run_q && !dir_q)
    else $error("forward terminal did not run forward");
  chk_term_reverse: assert property ( // [RULE6]
    (cmd_src == CMD_SRC_TERMINAL && rev_en && !fwd_en) |=> run_q && dir_q)
    else $error("reverse terminal did not run reverse");
  chk_term_idle: assert property ( // [RULE7]
    (cmd_src == CMD_SRC_TERMINAL && fwd_en == rev_en) |=> !run_q)
    else $error("terminals equal but run held");
  chk_src_other: assert property ( // [RULE1]
    (cmd_src != CMD_SRC_KEYPAD && cmd_src != CMD_SRC_TERMINAL) |=> !run_q)
    else $error("unsupported command source ran");
  chk_key_ignored: assert property ( // [RULE13]
    (freq_src != FREQ_SRC_KEYPAD && !sp_wr) |=> $stable(setpt_q))
    else $error("setpoint moved from unselected source");
  chk_key_up: assert property ( // [RULE9]
    (key_up && !key_dn && !sp_wr && setpt_q <= FREQ_MAX - FREQ_KEY_STEP)
    |=> setpt_q == $past(setpt_q) + FREQ_KEY_STEP)
    else $error("up key did not raise setpoint");
  chk_analog_src: assert property ( // [RULE10]
    (freq_src == FREQ_SRC_ANALOG)
    |-> src_freq == ((ana_fn == FUNC_ANALOG_FREQ) ? ana_freq : 16'h0000))
    else $error("analogue source selection wrong");
  chk_ramp_step: assert property ( // [RULE12]
    !$stable(freq_q) |-> $past(ramp_step) && $past(tick))
    else $error("output frequency moved off a ramp step");
endmodule

// File: include/drcs_pkg.sv
// Constants for the drive run-command and setpoint selection block.
// Assumes a 40 MHz core clock and a 32-bit classic Wishbone register bus.
package drcs_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_SRC_SEL = 8'h00;
  localparam logic [7:0] REG_IN_FUNC = 8'h04;
  localparam logic [7:0] REG_SETPOINT = 8'h08;
  localparam logic [7:0] REG_ACCEL = 8'h0c;
  localparam logic [7:0] REG_DECEL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // ----------------------------------------------------------------------
  // Field layout and writable masks
  // ----------------------------------------------------------------------
  localparam int SRC_FREQ_LSB = 0;
  localparam int SRC_CMD_LSB = 8;
  localparam int FUNC_FWD_LSB = 0;
  localparam int FUNC_REV_LSB = 8;
  localparam int FUNC_ANA_LSB = 16;
  localparam int STAT_RUN_BIT = 16;
  localparam int STAT_REV_BIT = 17;
  localparam int STAT_CMD_BIT = 18;
  localparam logic [31:0] MASK_SRC_SEL = 32'h0000_0303;
  localparam logic [31:0] MASK_IN_FUNC = 32'h000f_0f0f;
  localparam logic [31:0] MASK_HALF = 32'h0000_ffff;

  // ----------------------------------------------------------------------
  // Selection codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMD_SRC_KEYPAD = 2'h0;
  localparam logic [1:0] CMD_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] FREQ_SRC_KEYPAD = 2'h0;
  localparam logic [1:0] FREQ_SRC_ANALOG = 2'h3;
  localparam logic [3:0] FUNC_FORWARD_RUN = 4'h2;
  localparam logic [3:0] FUNC_REVERSE_RUN = 4'h3;
  localparam logic [3:0] FUNC_ANALOG_FREQ = 4'h2;

  // ----------------------------------------------------------------------
  // Reset values (frequency in 0.01 Hz units)
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_SRC_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_IN_FUNC = 32'h0002_0302;
  localparam logic [15:0] RST_SETPOINT = 16'h1388;
  localparam logic [15:0] RST_ACCEL = 16'h00c8;
  localparam logic [15:0] RST_DECEL = 16'h00c8;
  localparam logic [15:0] FREQ_MAX = 16'h2710;
  localparam logic [15:0] FREQ_KEY_STEP = 16'h000a;

  // ----------------------------------------------------------------------
  // Timing: ramp base tick
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Synchronised pin indices
  localparam int PIN_RUN = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_UP = 2;
  localparam int PIN_DOWN = 3;
  localparam int PIN_FWD = 4;
  localparam int PIN_REV = 5;
  localparam int PIN_N = 6;

endpackage

// File: testbench/drcs_operator.sv
// Operator model: keypad keys and the forward/reverse switch contacts.
// Assumes the bench calls its tasks from a process tied to the core clock.
`timescale 1ns/1ps

module drcs_operator
  import drcs_pkg::*;
(
  input wire logic i_clk,
  output logic [3:0] o_keys,
  output logic o_fwd,
  output logic o_rev
);
  // Open contacts read low through their pull-downs
  initial begin
    o_keys = 4'h0;
    o_fwd = 1'b0;
    o_rev = 1'b0;
  end

  // Key held past the input synchroniser, then released for as long
  task automatic press(input int k);
    @(posedge i_clk);
    o_keys[k] <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_keys[k] <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  // Switch levels change together just after an edge
  task automatic switches(input logic f, input logic r);
    @(posedge i_clk);
    o_fwd <= f;
    o_rev <= r;
  endtask
endmodule

// File: testbench/drive_run_command_select_tb_top.sv
// Self-checking bench for the run-command and setpoint selection block.
// Assumes the operator model in its own file and a 1-cycle ramp tick.
`timescale 1ns/1ps

module drive_run_command_select_tb_top;
  import drcs_pkg::*;
  logic i_core_clk, i_rst, cyc, stb, we, ack, o_reverse, o_running, fwd, rev;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, r;
  logic [15:0] ana, freq;
  logic [3:0] keys;
  logic [3:0] sel, sel_v;
  logic [1:0] sw_seq [5] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b00};
  logic [7:0] ra [5] = '{REG_SRC_SEL, REG_IN_FUNC, REG_SETPOINT, REG_ACCEL, REG_DECEL};
  logic [31:0] rv [5];
  int n_fail, comparisons, seed, m_cmd, m_fsrc, m_ffn, m_rfn, m_afn, m_sp, m_krun, m_fwd, m_rev;
  longint t0, t_hit;

  drcs_core #(.TICK_CYC(1)) DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_key_run(keys[PIN_RUN]), .i_key_stop(keys[PIN_STOP]),
    .i_key_up(keys[PIN_UP]), .i_key_down(keys[PIN_DOWN]), .i_forward_run_input(fwd),
    .i_reverse_run_input(rev), .i_analog_input_one(ana), .o_out_freq(freq),
    .o_reverse(o_reverse), .o_running(o_running));
  drcs_operator op (.i_clk(i_core_clk), .o_keys(keys), .o_fwd(fwd), .o_rev(rev));

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  function automatic int m_run();
    if (m_cmd == 0) return m_krun;
    if (m_cmd != 1) return 0;
    return int'(m_fwd == 1 && m_ffn == 2) ^ int'(m_rev == 1 && m_rfn == 3);
  endfunction
  function automatic int m_tgt();
    if (m_run() == 0) return 0;
    if (m_fsrc == 0) return m_sp;
    if (m_fsrc == 3 && m_afn == 2) return (ana > FREQ_MAX) ? int'(FREQ_MAX) : int'(ana);
    return 0;
  endfunction

  // ----------------------------------------------------------------------
  // Checks, bus cycles and closing
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= sel_v;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    if (n >= 50) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic settle(input string what);
    int n, e;
    n = 0;
    repeat (6) @(posedge i_core_clk);
    e = m_tgt();
    while (freq !== e[15:0] && n < 20000) begin
      @(posedge i_core_clk);
      n++;
    end
    t_hit = $time;
    repeat (3) @(posedge i_core_clk);
    chk(freq, e, what);
    chk(o_running, m_run() != 0, what);
    if (e != 0) chk(o_reverse, m_cmd == 1 && m_rev == 1, what);
  endtask
  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Core clock, 25 ns
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // Watchdog
  initial begin
    repeat (90000) @(posedge i_core_clk);
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {cyc, stb, we, adr, wdat, ana, i_rst} = {43'h0, 16'h0, 1'b1};
    rv = '{RST_SRC_SEL, RST_IN_FUNC, {16'h0, RST_SETPOINT}, {16'h0, RST_ACCEL},
      {16'h0, RST_DECEL}};
    {seed, m_cmd, m_fsrc, m_ffn, m_rfn, m_afn, m_sp} = {32'd84148, 32'd0, 32'd0, 32'd2,
      32'd3, 32'd2, 32'h1388};
    {m_krun, m_fwd, m_rev} = 96'h0;
    {sel, sel_v} = 8'h0f;
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    wb(1'b1, REG_STATUS, 32'hffff_ffff);
    wb(1'b1, 8'h40, 32'h0000_0055);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ra[i], 32'h0);
      chk(r, rv[i], "register reset value");
    end
    wb(1'b0, REG_STATUS, 32'h0);
    chk(r, 32'h0, "status after write");
    wb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0, "unmapped read");
    sel_v = 4'h1;
    wb(1'b1, REG_ACCEL, 32'h0000_ab12);
    sel_v = 4'hf;
    wb(1'b0, REG_ACCEL, 32'h0);
    chk(r, 32'h0000_0012, "byte lane write");
    $display("test 1 done: registers");
    wb(1'b1, REG_SETPOINT, 32'h14);
    wb(1'b1, REG_ACCEL, 32'h3);
    wb(1'b1, REG_DECEL, 32'h1);
    m_sp = 20;
    t0 = $time;
    op.press(PIN_RUN);
    m_krun = 1;
    settle("keypad run");
    chk((t_hit - t0) / 25 inside {[78:92]}, 1'b1, "accel time");
    op.press(PIN_UP);
    m_sp += 10;
    settle("up key");
    op.press(PIN_DOWN);
    m_sp -= 10;
    settle("down key");
    m_sp = 16 + ($random(seed) & 63);
    wb(1'b1, REG_SETPOINT, m_sp);
    settle("setpoint write");
    op.switches(1'b1, 1'b0);
    settle("switch in keypad mode");
    op.switches(1'b0, 1'b0);
    t0 = $time;
    op.press(PIN_STOP);
    m_krun = 0;
    settle("stop key");
    chk((t_hit - t0) / 25 inside {[2 * m_sp : 2 * m_sp + 14]}, 1'b1, "decel time");
    $display("test 2 done: keypad");
    wb(1'b1, REG_SRC_SEL, 32'h100);
    m_cmd = 1;
    op.press(PIN_RUN);
    settle("key in terminal mode");
    for (int i = 0; i < 5; i++) begin
      op.switches(sw_seq[i][1], sw_seq[i][0]);
      {m_fwd, m_rev} = {31'h0, sw_seq[i][1], 31'h0, sw_seq[i][0]};
      settle("switch pattern");
    end
    wb(1'b1, REG_SRC_SEL, 32'h200);
    op.switches(1'b1, 1'b0);
    {m_cmd, m_fwd, m_rev} = {32'd2, 32'd1, 32'd0};
    settle("unsupported command source");
    wb(1'b1, REG_IN_FUNC, 32'h0002_0000);
    {m_ffn, m_rfn} = 64'h0;
    wb(1'b1, REG_SRC_SEL, 32'h100);
    m_cmd = 1;
    op.switches(1'b1, 1'b0);
    m_fwd = 1;
    settle("forward function off");
    op.switches(1'b0, 1'b1);
    {m_fwd, m_rev} = {32'd0, 32'd1};
    settle("reverse function off");
    $display("test 3 done: terminals");
    wb(1'b1, REG_IN_FUNC, RST_IN_FUNC);
    wb(1'b1, REG_SRC_SEL, 32'h103);
    wb(1'b1, REG_ACCEL, 32'h0);
    {m_ffn, m_rfn, m_fsrc, m_fwd, m_rev} = {32'd2, 32'd3, 32'd3, 32'd1, 32'd0};
    op.switches(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ana <= (i == 3) ? 16'hffff : 16'($random(seed) & 32'h0fff);
      settle("analogue setpoint");
    end
    op.press(PIN_UP);
    wb(1'b0, REG_SETPOINT, 32'h0);
    chk(r, m_sp, "up key in analogue mode");
    wb(1'b1, REG_IN_FUNC, 32'h0000_0302);
    m_afn = 0;
    settle("analogue function off");
    wb(1'b1, REG_SRC_SEL, 32'h100);
    m_fsrc = 0;
    settle("back to keypad setpoint");
    $display("test 4 done: analogue");
    finish_test();
  end
endmodule
